// [hw/lrms_pkg.sv]
package lrms_pkg;

  // register location and field positions of the control/status byte
  localparam logic [7:0] LRMS_TOP_RATE_CONTROL_STATUS_ADDR = 8'h77;
  localparam int         LRMS_BIT_RX_UNLOCKED              = 0;
  localparam int         LRMS_BIT_TX_UNLOCKED              = 1;
  localparam int         LRMS_BIT_MODE_ENABLE              = 2;
  localparam int         LRMS_BIT_RX_READY                 = 3;
  localparam int         LRMS_BIT_TX_READY                 = 4;
  localparam logic       LRMS_MODE_ENABLE_RST              = 1'b0;

  // configuration timing
  localparam int CLK_MHZ              = 50;
  localparam int LRMS_ENTER_MAX_MS    = 2000;
  localparam int LRMS_EXIT_MAX_MS     = 500;
  // longest times convert to cycles exactly; products sized in 64 bits
  localparam longint LRMS_ENTER_CYC   = longint'(LRMS_ENTER_MAX_MS) * 1000 *
                                        CLK_MHZ;
  localparam longint LRMS_EXIT_CYC    = longint'(LRMS_EXIT_MAX_MS) * 1000 *
                                        CLK_MHZ;

  typedef enum logic [1:0] {
    LRMS_RATE_LOW = 2'b00,
    LRMS_RATE_MID = 2'b01,
    LRMS_RATE_TOP = 2'b10
  } lrms_rate_e;

endpackage : lrms_pkg

// [hw/lrms_cfg_seq.sv]
`timescale 1ns/1ns
`default_nettype none
// per-direction configuration sequencer: waits for done or a settle count, then ready if the target is top mode
module lrms_cfg_seq
  import lrms_pkg::*;
#(
  parameter int unsigned SETTLE = 32'd100
) (
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  input  wire logic i_top,
  input  wire logic i_done,
  output logic      o_ready,
  output logic      o_busy
);

  typedef struct packed {
    logic        ready;
    logic        busy;
    logic        tgt;
    logic [31:0] cnt;
  } lrms_seq_s;

  lrms_seq_s st_ff;
  lrms_seq_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (i_top != st_ff.tgt) begin
      // a mode change restarts configuration; ready drops at once
      nxt_st.tgt   = i_top;
      nxt_st.busy  = 1'b1;
      nxt_st.ready = 1'b0;
      nxt_st.cnt   = '0;
    end else if (st_ff.busy) begin
      if (i_done || st_ff.cnt >= SETTLE - 32'd1) begin
        nxt_st.busy  = 1'b0;
        nxt_st.ready = st_ff.tgt;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'd1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_ready = st_ff.ready;
  assign o_busy  = st_ff.busy;

endmodule : lrms_cfg_seq
`default_nettype wire

// [hw/lrms_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - All rate inputs and mode bit zero: both directions at lowest rate, NRZ.
// - Mode bit zero and any pin or soft bit set: middle rate, NRZ.
// - Transmit and receive always share one rate and mode.
// - Mode bit 2 one selects PAM4 top rate; pins and soft bits ignored.
// - Mode bit comes up zero after reset.
// - Status bit 4 set when transmit side finished top-rate configuration.
// - Status bit 3 set when receive side finished top-rate configuration.
// - Bit 1 is transmit recovery unlocked; in top rate also adaptation.
// - Bit 0 is receive recovery unlocked; in top rate also adaptation.
// - Entering top-rate mode completes within 2000 ms.
// - Leaving top-rate mode completes within 500 ms.
module lrms_top
  import lrms_pkg::*;
#(
  parameter longint ENTER_CYC = LRMS_ENTER_CYC,
  parameter longint EXIT_CYC  = LRMS_EXIT_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire logic       i_rate_pin_first,
  input  wire logic       i_rate_pin_second,
  input  wire logic       i_soft_rate_first,
  input  wire logic       i_soft_rate_second,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_tx_adapt_done,
  input  wire logic       i_rx_adapt_done,
  input  wire logic       i_tx_recovery_locked,
  input  wire logic       i_rx_recovery_locked,
  output logic      [1:0] o_rate,
  output logic            o_pam4
);

  typedef struct packed {
    logic       mode_en;
    logic [1:0] rate;
    logic       pam4;
    logic [7:0] rdata;
  } lrms_top_s;

  lrms_top_s  st_ff;
  lrms_top_s  nxt_st;
  logic       tx_ready;
  logic       rx_ready;
  logic       tx_busy;
  logic       rx_busy;
  logic       tx_unlocked;
  logic       rx_unlocked;
  logic [7:0] status_byte;
  logic       hit;

  ////////////////////////////////////////////////////////////////////////
  // shared settle bound
  // one settle limit serves both directions of change
  localparam int unsigned SET_IN  = 32'(ENTER_CYC);
  localparam int unsigned SET_OUT = 32'(EXIT_CYC);
  // shorter of the two bounds keeps both directions inside their limits
  localparam int unsigned SETTLE  = (SET_IN < SET_OUT) ? SET_IN : SET_OUT;

  lrms_cfg_seq #(.SETTLE(SETTLE)) u_tx_seq (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_top   (st_ff.mode_en),
    .i_done  (i_tx_adapt_done),
    .o_ready (tx_ready),
    .o_busy  (tx_busy)
  );

  lrms_cfg_seq #(.SETTLE(SETTLE)) u_rx_seq (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_top   (st_ff.mode_en),
    .i_done  (i_rx_adapt_done),
    .o_ready (rx_ready),
    .o_busy  (rx_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // tx and rx unlock flags
  // in top rate, lock only counts once configuration finished
  assign tx_unlocked = !i_tx_recovery_locked || tx_busy ||
                       (st_ff.mode_en && !tx_ready);
  assign rx_unlocked = !i_rx_recovery_locked || rx_busy ||
                       (st_ff.mode_en && !rx_ready);

  always_comb begin
    status_byte = 8'h00;
    status_byte[LRMS_BIT_TX_READY]     = tx_ready;
    status_byte[LRMS_BIT_RX_READY]     = rx_ready;
    status_byte[LRMS_BIT_MODE_ENABLE]  = st_ff.mode_en;
    status_byte[LRMS_BIT_TX_UNLOCKED]  = tx_unlocked;
    status_byte[LRMS_BIT_RX_UNLOCKED]  = rx_unlocked;
  end

  assign hit = (i_reg_addr == LRMS_TOP_RATE_CONTROL_STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    // only the mode bit is writable
    if (i_reg_wr && hit) begin
      nxt_st.mode_en = i_reg_wdata[LRMS_BIT_MODE_ENABLE];
    end
    if (i_reg_rd) begin
      nxt_st.rdata = hit ? status_byte : 8'h00;
    end
    if (st_ff.mode_en) begin
      nxt_st.rate = LRMS_RATE_TOP;
      nxt_st.pam4 = 1'b1;
    // any rate input gives middle rate
    end else if (i_rate_pin_first || i_rate_pin_second ||
                 i_soft_rate_first || i_soft_rate_second) begin
      nxt_st.rate = LRMS_RATE_MID;
      nxt_st.pam4 = 1'b0;
    end else begin
      nxt_st.rate = LRMS_RATE_LOW;
      nxt_st.pam4 = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff.mode_en <= LRMS_MODE_ENABLE_RST;
      st_ff.rate    <= LRMS_RATE_LOW;
      st_ff.pam4    <= 1'b0;
      st_ff.rdata   <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // one shared rate output for both directions
  assign o_rate      = st_ff.rate;
  assign o_pam4      = st_ff.pam4;
  assign o_reg_rdata = st_ff.rdata;

  ////////////////////////////////////////////////////////////////////////
  AST_TOP_RATE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    st_ff.mode_en |=> (o_rate == LRMS_RATE_TOP && o_pam4))
    else $error("top rate not selected");
  AST_LOW_RATE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!st_ff.mode_en && !i_rate_pin_first && !i_rate_pin_second &&
     !i_soft_rate_first && !i_soft_rate_second)
    |=> (o_rate == LRMS_RATE_LOW && !o_pam4))
    else $error("low rate not selected");
  AST_MID_RATE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!st_ff.mode_en && (i_rate_pin_first || i_rate_pin_second ||
                        i_soft_rate_first || i_soft_rate_second))
    |=> (o_rate == LRMS_RATE_MID && !o_pam4))
    else $error("middle rate not selected");
  AST_PAM4_TIE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_pam4 == (o_rate == LRMS_RATE_TOP))
    else $error("rate and mode disagree");
  AST_TX_READY: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    tx_ready |-> $past(st_ff.mode_en) && !tx_busy)
    else $error("tx ready outside top mode");
  AST_RX_READY: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(rx_ready) |-> $past(st_ff.mode_en))
    else $error("rx ready without mode");
  AST_TX_LOCK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !i_tx_recovery_locked |-> status_byte[LRMS_BIT_TX_UNLOCKED])
    else $error("tx unlock not flagged");
  AST_RX_LOCK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_ff.mode_en && !rx_ready) |-> status_byte[LRMS_BIT_RX_UNLOCKED])
    else $error("rx lock shown before ready");
  AST_UNALLOC: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_reg_rd && hit) |=> (o_reg_rdata[7:5] == 3'b000))
    else $error("unallocated bits not zero");
  AST_ENTER: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(st_ff.mode_en) && i_tx_adapt_done && i_rx_adapt_done
    ##1 (st_ff.mode_en && i_tx_adapt_done && i_rx_adapt_done)
    |=> (tx_ready && rx_ready))
    else $error("top mode configuration late");

endmodule : lrms_top
`default_nettype wire

// [testbench/lrms_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// host side of the management bus: one strobe cycle per access
module lrms_host_model (
  input  wire logic       i_mclk,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_wr    = w;
    o_rd    = !w;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_mclk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    // released lines show the inverse so stale values never match
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : acc
endmodule : lrms_host_model
`default_nettype wire

// [testbench/tb_link_rate_mode_select.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_link_rate_mode_select;
  import lrms_pkg::*;
  logic       clk = 1'b0;
  logic       nrst, wr, rd, txd, rxd, txl, rxl, pam, rd_d;
  logic [3:0] rs;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] rt;
  logic [7:0] q[$];
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         seed;
  always #10 clk = ~clk;
  lrms_host_model host (.i_mclk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));
  lrms_top #(.ENTER_CYC(20), .EXIT_CYC(20)) dut (.i_mclk(clk),
    .i_nrst(nrst), .i_rate_pin_first(rs[0]), .i_rate_pin_second(rs[1]),
    .i_soft_rate_first(rs[2]), .i_soft_rate_second(rs[3]), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_tx_adapt_done(txd), .i_rx_adapt_done(rxd),
    .i_tx_recovery_locked(txl), .i_rx_recovery_locked(rxl), .o_rate(rt),
    .o_pam4(pam));
  task automatic chk(input string nm, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic rdx(input logic [7:0] a, exp);
    q.push_back(exp);
    host.acc(1'b0, a, 8'h00);
  endtask : rdx
  task automatic rate(input lrms_rate_e e);
    repeat (2) @(negedge clk);
    chk("rate", {6'h00, rt}, 8'(e));
    chk("pam4", {7'h00, pam}, {7'h00, e == LRMS_RATE_TOP});
  endtask : rate
  ////////////////////////////////////////////////////////////
  // read data settles on the strobe edge; compared half a cycle on
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && q.size() > 0) begin
      chk("rdata", rdata, q.pop_front());
    end
  end
  initial begin
    #200_000;
    n_mismatch++;
    summarize();
  end
  initial begin
    seed = 80;
    {nrst, rs, txd, rxd, txl, rxl} = 9'h003;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rdx(8'h77, 8'h00);
    rate(LRMS_RATE_LOW);
    for (int i = 0; i < 8; i++) begin
      rs = 4'($random(seed)) | 4'(1 << (i % 4));
      rate(LRMS_RATE_MID);
    end
    rs = 4'h0;
    rate(LRMS_RATE_LOW);
    $display("rate table done");
    // tx finishes early, rx waits out its settle count
    txd = 1'b1;
    host.acc(1'b1, 8'h77, 8'hff);
    rs = 4'($random(seed));
    rate(LRMS_RATE_TOP);
    rdx(8'h77, 8'h15);
    repeat (30) @(negedge clk);
    rdx(8'h77, 8'h1c);
    txl = 1'b0;
    rdx(8'h77, 8'h1e);
    {txl, rxl} = 2'b10;
    rdx(8'h77, 8'h1d);
    rxl = 1'b1;
    rdx(8'h76, 8'h00);
    host.acc(1'b1, 8'h76, 8'h00);
    rdx(8'h77, 8'h1c);
    $display("top rate done");
    host.acc(1'b1, 8'h77, 8'h00);
    rs = 4'h0;
    repeat (30) @(negedge clk);
    rate(LRMS_RATE_LOW);
    rdx(8'h77, 8'h00);
    $display("exit done");
    // both sides report adaptation done: ready two edges after mode
    rxd = 1'b1;
    host.acc(1'b1, 8'h77, 8'h04);
    rdx(8'h77, 8'h07);
    rdx(8'h77, 8'h1c);
    $display("fast entry done");
    // reset in mid-run must drop the mode bit again
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rdx(8'h77, 8'h00);
    rate(LRMS_RATE_LOW);
    repeat (4) @(negedge clk);
    $display("reset done");
    summarize();
  end
endmodule : tb_link_rate_mode_select
`default_nettype wire
